// ---- design/card_port_pkg.sv ----
// Constants and types for the dual card port block.
// Assumes a 40 MHz system clock and a separate card link clock.
package card_port_pkg;

	// ----------------------------------------
	// Port selection
	// ----------------------------------------
	localparam logic PORT_A = 1'b0;
	localparam logic PORT_B = 1'b1;
	localparam logic SELECT_RESET = PORT_A;

	// ----------------------------------------
	// Supply class encoding
	// ----------------------------------------
	localparam logic CLASS_2V85 = 1'b0;
	localparam logic CLASS_1V8 = 1'b1;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int SYS_CLK_MHZ = 40;
	localparam int CARD_RESET_US = 10;
	localparam int CARD_RESET_CYC = (CARD_RESET_US * SYS_CLK_MHZ > 0) ?
		CARD_RESET_US * SYS_CLK_MHZ : 1;
	localparam int CLK_DIV_DEFAULT = 4;

	// Per-port activation states
	typedef enum logic [1:0] {
		ST_OFF,
		ST_RESET,
		ST_ACTIVE,
		ST_REMOVED
	} port_state_t;

endpackage

// ---- design/level_sync.sv ----
// Two-flop synchroniser for single-bit levels.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ps
module level_sync #(
	parameter logic RESET_VALUE = 1'b0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic async_in,
	output logic sync_out
);
	logic meta_ff;

	// First flop feeds only the second
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_ff <= RESET_VALUE;
			sync_out <= RESET_VALUE;
		end else begin
			meta_ff <= async_in;
			sync_out <= meta_ff;
		end
	end
endmodule

// ---- design/card_link_port.sv ----
// One card port on the link clock: clock divider, data line, reset line.
// Assumes enable and reset request arrive synchronised to link_clk.
`timescale 1ns/1ps
module card_link_port #(
	parameter int DIV = card_port_pkg::CLK_DIV_DEFAULT
) (
	input wire logic link_clk,
	input wire logic rst,
	input wire logic enable,
	input wire logic hold_reset,
	input wire logic tx_bit,
	input wire logic tx_drive,
	input wire logic data_in,
	output logic card_clock,
	output logic card_reset,
	output logic data_out,
	output logic data_oe,
	output logic rx_bit
);
	localparam int CW = $clog2(DIV) + 1;
	localparam logic [CW-1:0] HALF = CW'(DIV / 2 - 1);
	logic [CW-1:0] div_ff;
	wire half_done = (div_ff == HALF);

	// Card clock runs only while enabled
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			div_ff <= '0;
			card_clock <= 1'b0;
		end else if (!enable) begin
			div_ff <= '0;
			card_clock <= 1'b0;
		end else begin
			div_ff <= half_done ? '0 : div_ff + CW'(1);
			card_clock <= half_done ? ~card_clock : card_clock;
		end
	end

	// Reset line, data drive and receive sampling
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			card_reset <= 1'b0;
			data_out <= 1'b0;
			data_oe <= 1'b0;
			rx_bit <= 1'b1;
		end else begin
			card_reset <= enable & ~hold_reset;
			data_out <= tx_bit;
			data_oe <= enable & tx_drive & ~tx_bit;
			rx_bit <= data_in;
		end
	end
endmodule

// ---- design/dual_card_port.sv ----
// Top of the dual smart card port: selection, supply control, removal shutdown.
// Assumes the selection store is retained externally; link_clk is free running.
`timescale 1ns/1ps

module dual_card_port (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic link_clk,
	input wire logic select_cmd_valid,
	input wire logic select_cmd_port,
	input wire logic nv_select,
	input wire logic nv_valid,
	input wire logic supply_class,
	input wire logic tx_bit_a,
	input wire logic tx_drive_a,
	input wire logic tx_bit_b,
	input wire logic tx_drive_b,
	input wire logic tray_present_n_port_a,
	input wire logic tray_present_n_port_b,
	input wire logic card_data_port_a_in,
	input wire logic card_data_port_b_in,
	output logic card_clock_port_a,
	output logic card_clock_port_b,
	output logic card_reset_port_a,
	output logic card_reset_port_b,
	output logic card_data_port_a_out,
	output logic card_data_port_a_oe,
	output logic card_data_port_b_out,
	output logic card_data_port_b_oe,
	output logic card_supply_port_a,
	output logic card_supply_port_b,
	output logic supply_class_sel_ff,
	output logic active_port_ff,
	output logic nv_write_ff,
	output logic nv_data_ff,
	output logic removed_a_ff,
	output logic removed_b_ff,
	output logic rx_bit_a_ff,
	output logic rx_bit_b_ff
);
	// ------------------------------------------------------------
	// Tray detection synchronisers
	// ------------------------------------------------------------
	logic tray_n_a_sync;
	logic tray_n_b_sync;

	level_sync #(.RESET_VALUE(1'b1)) u_sync_tray_a (
		.clk(sys_clk),
		.rst(rst),
		.async_in(tray_present_n_port_a),
		.sync_out(tray_n_a_sync)
	);

	level_sync #(.RESET_VALUE(1'b1)) u_sync_tray_b (
		.clk(sys_clk),
		.rst(rst),
		.async_in(tray_present_n_port_b),
		.sync_out(tray_n_b_sync)
	);

	// Low level means present
	wire present_a = ~tray_n_a_sync;
	wire present_b = ~tray_n_b_sync;

	// ------------------------------------------------------------
	// Selection and non-volatile store
	// ------------------------------------------------------------
	logic nv_loaded_ff;
	wire nxt_active_port = select_cmd_valid ? select_cmd_port :
		(!nv_loaded_ff && nv_valid) ? nv_select : active_port_ff;

	// Reset selects first port; store loads once, commands write back
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			active_port_ff <= card_port_pkg::SELECT_RESET;
			nv_loaded_ff <= 1'b0;
			nv_write_ff <= 1'b0;
			nv_data_ff <= card_port_pkg::SELECT_RESET;
			supply_class_sel_ff <= card_port_pkg::CLASS_2V85;
		end else begin
			active_port_ff <= nxt_active_port;
			nv_loaded_ff <= nv_loaded_ff | nv_valid;
			nv_write_ff <= select_cmd_valid;
			nv_data_ff <= select_cmd_valid ? select_cmd_port : nv_data_ff;
			supply_class_sel_ff <= supply_class;
		end
	end

	// ------------------------------------------------------------
	// Per-port sequencing
	// ------------------------------------------------------------
	card_port_pkg::port_state_t state_a_ff;
	card_port_pkg::port_state_t state_b_ff;
	card_port_pkg::port_state_t nxt_state_a;
	card_port_pkg::port_state_t nxt_state_b;
	logic [15:0] rst_cnt_a_ff;
	logic [15:0] rst_cnt_b_ff;
	localparam logic [15:0] RST_LAST = 16'(card_port_pkg::CARD_RESET_CYC - 1);

	wire sel_a = (active_port_ff == card_port_pkg::PORT_A);
	wire sel_b = (active_port_ff == card_port_pkg::PORT_B);

	// Next state for one port
	function automatic card_port_pkg::port_state_t next_state(
		input card_port_pkg::port_state_t cur,
		input logic selected,
		input logic present,
		input logic cnt_done
	);
		card_port_pkg::port_state_t res;
		res = cur;
		case (cur)
			card_port_pkg::ST_OFF: begin
				if (selected && present) begin
					res = card_port_pkg::ST_RESET;
				end
			end
			card_port_pkg::ST_RESET: begin
				if (!present) begin
					res = card_port_pkg::ST_REMOVED;
				end else if (!selected) begin
					res = card_port_pkg::ST_OFF;
				end else if (cnt_done) begin
					res = card_port_pkg::ST_ACTIVE;
				end
			end
			card_port_pkg::ST_ACTIVE: begin
				if (!present) begin
					res = card_port_pkg::ST_REMOVED;
				end else if (!selected) begin
					res = card_port_pkg::ST_OFF;
				end
			end
			card_port_pkg::ST_REMOVED: res = card_port_pkg::ST_REMOVED;
			default: res = card_port_pkg::ST_OFF;
		endcase
		return res;
	endfunction

	assign nxt_state_a = next_state(state_a_ff, sel_a, present_a, rst_cnt_a_ff == RST_LAST);
	assign nxt_state_b = next_state(state_b_ff, sel_b, present_b, rst_cnt_b_ff == RST_LAST);

	// Removal is immediate: supply dropped at the edge after it is seen
	wire nxt_supply_a = (nxt_state_a == card_port_pkg::ST_RESET) ||
		(nxt_state_a == card_port_pkg::ST_ACTIVE);
	wire nxt_supply_b = (nxt_state_b == card_port_pkg::ST_RESET) ||
		(nxt_state_b == card_port_pkg::ST_ACTIVE);

	// State, reset counters and supply switches
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_a_ff <= card_port_pkg::ST_OFF;
			state_b_ff <= card_port_pkg::ST_OFF;
			rst_cnt_a_ff <= '0;
			rst_cnt_b_ff <= '0;
			card_supply_port_a <= 1'b0;
			card_supply_port_b <= 1'b0;
		end else begin
			state_a_ff <= nxt_state_a;
			state_b_ff <= nxt_state_b;
			rst_cnt_a_ff <= (nxt_state_a == card_port_pkg::ST_RESET &&
				state_a_ff == card_port_pkg::ST_RESET) ? rst_cnt_a_ff + 16'h0001 : 16'h0000;
			rst_cnt_b_ff <= (nxt_state_b == card_port_pkg::ST_RESET &&
				state_b_ff == card_port_pkg::ST_RESET) ? rst_cnt_b_ff + 16'h0001 : 16'h0000;
			card_supply_port_a <= nxt_supply_a;
			card_supply_port_b <= nxt_supply_b;
		end
	end

	// Sticky removal flags, cleared only by reset
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			removed_a_ff <= 1'b0;
			removed_b_ff <= 1'b0;
		end else begin
			removed_a_ff <= removed_a_ff | (nxt_state_a == card_port_pkg::ST_REMOVED);
			removed_b_ff <= removed_b_ff | (nxt_state_b == card_port_pkg::ST_REMOVED);
		end
	end

	// ------------------------------------------------------------
	// Crossing into the link clock domain
	// ------------------------------------------------------------
	logic hold_a_ff;
	logic hold_b_ff;
	logic link_rst;
	logic tx_bit_a_l;
	logic tx_drive_a_l;
	logic tx_bit_b_l;
	logic tx_drive_b_l;
	logic en_a_l;
	logic en_b_l;
	logic hold_a_l;
	logic hold_b_l;
	logic rx_a_l;
	logic rx_b_l;
	logic rx_a_s;
	logic rx_b_s;

	// Hold request from a flop, so the crossing never sees a decode glitch
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			hold_a_ff <= 1'b1;
			hold_b_ff <= 1'b1;
		end else begin
			hold_a_ff <= (nxt_state_a != card_port_pkg::ST_ACTIVE);
			hold_b_ff <= (nxt_state_b != card_port_pkg::ST_ACTIVE);
		end
	end

	// Reset leaves the link domain only on a link clock edge
	level_sync #(.RESET_VALUE(1'b1)) u_sync_link_rst (.clk(link_clk), .rst(rst),
		.async_in(1'b0), .sync_out(link_rst));
	level_sync u_sync_en_a (.clk(link_clk), .rst(link_rst), .async_in(card_supply_port_a),
		.sync_out(en_a_l));
	level_sync u_sync_en_b (.clk(link_clk), .rst(link_rst), .async_in(card_supply_port_b),
		.sync_out(en_b_l));
	level_sync #(.RESET_VALUE(1'b1)) u_sync_hold_a (.clk(link_clk), .rst(link_rst),
		.async_in(hold_a_ff), .sync_out(hold_a_l));
	level_sync #(.RESET_VALUE(1'b1)) u_sync_hold_b (.clk(link_clk), .rst(link_rst),
		.async_in(hold_b_ff), .sync_out(hold_b_l));

	// Transmit controls come from the system clock side
	level_sync #(.RESET_VALUE(1'b1)) u_sync_tx_bit_a (.clk(link_clk), .rst(link_rst),
		.async_in(tx_bit_a), .sync_out(tx_bit_a_l));
	level_sync u_sync_tx_drive_a (.clk(link_clk), .rst(link_rst), .async_in(tx_drive_a),
		.sync_out(tx_drive_a_l));
	level_sync #(.RESET_VALUE(1'b1)) u_sync_tx_bit_b (.clk(link_clk), .rst(link_rst),
		.async_in(tx_bit_b), .sync_out(tx_bit_b_l));
	level_sync u_sync_tx_drive_b (.clk(link_clk), .rst(link_rst), .async_in(tx_drive_b),
		.sync_out(tx_drive_b_l));

	// Port A and port B link logic
	card_link_port u_link_a (
		.link_clk(link_clk),
		.rst(link_rst),
		.enable(en_a_l),
		.hold_reset(hold_a_l),
		.tx_bit(tx_bit_a_l),
		.tx_drive(tx_drive_a_l),
		.data_in(card_data_port_a_in),
		.card_clock(card_clock_port_a),
		.card_reset(card_reset_port_a),
		.data_out(card_data_port_a_out),
		.data_oe(card_data_port_a_oe),
		.rx_bit(rx_a_l)
	);

	card_link_port u_link_b (
		.link_clk(link_clk),
		.rst(link_rst),
		.enable(en_b_l),
		.hold_reset(hold_b_l),
		.tx_bit(tx_bit_b_l),
		.tx_drive(tx_drive_b_l),
		.data_in(card_data_port_b_in),
		.card_clock(card_clock_port_b),
		.card_reset(card_reset_port_b),
		.data_out(card_data_port_b_out),
		.data_oe(card_data_port_b_oe),
		.rx_bit(rx_b_l)
	);

	// Received bits back to the system clock
	level_sync #(.RESET_VALUE(1'b1)) u_sync_rx_a (.clk(sys_clk), .rst(rst),
		.async_in(rx_a_l), .sync_out(rx_a_s));
	level_sync #(.RESET_VALUE(1'b1)) u_sync_rx_b (.clk(sys_clk), .rst(rst),
		.async_in(rx_b_l), .sync_out(rx_b_s));

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rx_bit_a_ff <= 1'b1;
			rx_bit_b_ff <= 1'b1;
		end else begin
			rx_bit_a_ff <= rx_a_s;
			rx_bit_b_ff <= rx_b_s;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_removal_cuts_a: assert property (@(posedge sys_clk) disable iff (rst)
		(card_supply_port_a && !present_a) |=> !card_supply_port_a)
		else $error("port a supply kept after removal");
	a_removal_cuts_b: assert property (@(posedge sys_clk) disable iff (rst)
		(card_supply_port_b && !present_b) |=> !card_supply_port_b)
		else $error("port b supply kept after removal");
	a_one_supply_on: assert property (@(posedge sys_clk) disable iff (rst)
		!(card_supply_port_a && card_supply_port_b))
		else $error("both supplies on");
	a_select_follows: assert property (@(posedge sys_clk) disable iff (rst)
		select_cmd_valid |=> (active_port_ff == $past(select_cmd_port)))
		else $error("selection not taken");
	a_nv_write_cmd: assert property (@(posedge sys_clk) disable iff (rst)
		select_cmd_valid |=> (nv_write_ff && nv_data_ff == $past(select_cmd_port)))
		else $error("selection not stored");
	a_b_off_default: assert property (@(posedge sys_clk) disable iff (rst)
		(active_port_ff == card_port_pkg::PORT_A) |=> !card_supply_port_b)
		else $error("port b powered while not selected");
	a_present_low: assert property (@(posedge sys_clk) disable iff (rst)
		(tray_n_a_sync && tray_n_b_sync) |=> (!card_supply_port_a && !card_supply_port_b))
		else $error("supply on with no tray");
	a_removed_sticky: assert property (@(posedge sys_clk) disable iff (rst)
		removed_a_ff |=> (removed_a_ff && !card_supply_port_a))
		else $error("port a revived after removal");
	a_class_follows: assert property (@(posedge sys_clk) disable iff (rst)
		supply_class_sel_ff == $past(supply_class) || $past(rst))
		else $error("supply class not applied");
	a_a_off_on_b: assert property (@(posedge sys_clk) disable iff (rst)
		(active_port_ff == card_port_pkg::PORT_B) |=> !card_supply_port_a)
		else $error("port a powered while not selected");
	a_nv_write_pulse: assert property (@(posedge sys_clk) disable iff (rst)
		!select_cmd_valid |=> !nv_write_ff)
		else $error("store written without command");
endmodule

// ---- tb/card_holder_model.sv ----
// Card holder model: tray switch, card answering on its own clock.
// Assumes the bench decides insertion and when the card pulls the line.
`timescale 1ns/1ps
module card_holder_model (
	input wire logic card_supply,
	input wire logic card_clock,
	input wire logic card_reset,
	input wire logic dev_out,
	input wire logic dev_oe,
	input wire logic inserted,
	input wire logic card_pull,
	output logic tray_n,
	output logic line
);
	logic pull_ff;

	// Card pulls low on its clock only while powered and out of reset
	always_ff @(posedge card_clock or negedge card_supply) begin
		if (!card_supply) begin
			pull_ff <= 1'b0;
		end else begin
			pull_ff <= card_pull & card_reset;
		end
	end

	// Tray switch low when present, used for nothing else
	assign tray_n = ~inserted;
	// Open-drain line with pull-up, released lines read high
	assign line = ~((dev_oe & ~dev_out) | pull_ff);
endmodule

// ---- tb/dual_card_port_tb.sv ----
// Self-checking bench: select table, data line, removal and restart.
// Assumes card_holder_model on each port and a free link clock.
`timescale 1ns/1ps
module dual_card_port_tb;
	logic sys_clk = 0, link_clk = 0, rst = 1, cmd_v = 0, cmd_p = 0, nv_sel = 0, nv_v = 0;
	logic cls = 0, txa = 1, tda = 0, txb = 1, tdb = 0, ins_a = 1, ins_b = 1, pull_a = 0;
	logic tn_a, tn_b, ln_a, ln_b, clk_a, clk_b, rs_a, rs_b, do_a, oe_a, do_b, oe_b;
	logic sp_a, sp_b, cls_ff, act, nvw, nvd, rm_a, rm_b, rx_a, rx_b;
	int num_errors = 0;
	int checks = 0;
	typedef struct {logic port; logic cls;} row_t;
	row_t rows[4] = '{'{1'b1, 1'b1}, '{1'b0, 1'b0}, '{1'b1, 1'b0}, '{1'b0, 1'b1}};

	// Clocks of unrelated phase
	always #12.5 sys_clk = ~sys_clk;
	initial #7 forever #32 link_clk = ~link_clk;

	dual_card_port u_dual_card_port (.sys_clk(sys_clk), .rst(rst), .link_clk(link_clk),
		.select_cmd_valid(cmd_v), .select_cmd_port(cmd_p), .nv_select(nv_sel),
		.nv_valid(nv_v), .supply_class(cls), .tx_bit_a(txa), .tx_drive_a(tda),
		.tx_bit_b(txb), .tx_drive_b(tdb), .tray_present_n_port_a(tn_a),
		.tray_present_n_port_b(tn_b), .card_data_port_a_in(ln_a),
		.card_data_port_b_in(ln_b), .card_clock_port_a(clk_a), .card_clock_port_b(clk_b),
		.card_reset_port_a(rs_a), .card_reset_port_b(rs_b), .card_data_port_a_out(do_a),
		.card_data_port_a_oe(oe_a), .card_data_port_b_out(do_b), .card_data_port_b_oe(oe_b),
		.card_supply_port_a(sp_a), .card_supply_port_b(sp_b), .supply_class_sel_ff(cls_ff),
		.active_port_ff(act), .nv_write_ff(nvw), .nv_data_ff(nvd), .removed_a_ff(rm_a),
		.removed_b_ff(rm_b), .rx_bit_a_ff(rx_a), .rx_bit_b_ff(rx_b));

	card_holder_model u_holder_a (.card_supply(sp_a), .card_clock(clk_a), .card_reset(rs_a),
		.dev_out(do_a), .dev_oe(oe_a), .inserted(ins_a), .card_pull(pull_a),
		.tray_n(tn_a), .line(ln_a));
	card_holder_model u_holder_b (.card_supply(sp_b), .card_clock(clk_b), .card_reset(rs_b),
		.dev_out(do_b), .dev_oe(oe_b), .inserted(ins_b), .card_pull(1'b0),
		.tray_n(tn_b), .line(ln_b));

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic exp, input logic got);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %b seen %b", what, exp, got);
		end
	endtask

	// Bounded wait for a port's card reset to reach a level
	task automatic wait_rst(input logic port, input logic lvl);
		int n;
		n = 0;
		while (((port ? rs_b : rs_a) !== lvl) && n < 1000) begin
			@(negedge sys_clk);
			n++;
		end
		if ((port ? rs_b : rs_a) !== lvl) begin
			num_errors++;
			$display("MISMATCH card reset wait expected %b seen timeout", lvl);
			final_report();
		end
	endtask

	// Selected card clock toggles, the other stays low
	task automatic clk_probe(input logic port);
		logic hi, lo, other;
		hi = 0;
		lo = 0;
		other = 0;
		repeat (40) begin
			@(negedge sys_clk);
			hi |= port ? clk_b : clk_a;
			lo |= ~(port ? clk_b : clk_a);
			other |= port ? clk_a : clk_b;
		end
		check("card clock high", 1'b1, hi);
		check("card clock low", 1'b1, lo);
		check("idle card clock", 1'b0, other);
	endtask

	// Hang guard
	initial begin
		repeat (60000) @(posedge sys_clk);
		num_errors++;
		$display("MISMATCH run length expected end seen timeout");
		final_report();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (6) @(negedge sys_clk);
		rst = 0;
		check("active port", card_port_pkg::SELECT_RESET, act);
		check("supply b", 1'b0, sp_b);
		check("reset b", 1'b0, rs_b);
		repeat (4) @(negedge sys_clk);
		check("supply a default", 1'b1, sp_a);
		check("supply b default", 1'b0, sp_b);
		$display("test reset done");
		foreach (rows[i]) begin
			cls = rows[i].cls;
			cmd_p = rows[i].port;
			cmd_v = 1;
			@(negedge sys_clk);
			cmd_v = 0;
			check("active port", rows[i].port, act);
			check("store write", 1'b1, nvw);
			check("store data", rows[i].port, nvd);
			@(negedge sys_clk);
			check("selected supply", 1'b1, rows[i].port ? sp_b : sp_a);
			check("other supply", 1'b0, rows[i].port ? sp_a : sp_b);
			check("store write end", 1'b0, nvw);
			check("supply class", rows[i].cls, cls_ff);
			wait_rst(rows[i].port, 1'b1);
			check("other reset", 1'b0, rows[i].port ? rs_a : rs_b);
			clk_probe(rows[i].port);
			$display("test select row %0d done", i);
		end
		// Data line on the active port, idle port refuses to drive
		tda = 1;
		txa = 0;
		tdb = 1;
		txb = 0;
		repeat (24) @(negedge sys_clk);
		check("drive a", 1'b1, oe_a);
		check("drive b", 1'b0, oe_b);
		check("data out a", 1'b0, do_a);
		check("data out b", 1'b0, do_b);
		check("receive a low", 1'b0, rx_a);
		check("receive b idle", 1'b1, rx_b);
		txa = 1;
		repeat (24) @(negedge sys_clk);
		check("release a", 1'b0, oe_a);
		check("data out a high", 1'b1, do_a);
		check("receive a high", 1'b1, rx_a);
		pull_a = 1;
		repeat (24) @(negedge sys_clk);
		check("card to device", 1'b0, rx_a);
		pull_a = 0;
		tda = 0;
		tdb = 0;
		$display("test data done");
		// Removal: synchronised, then off at the third edge
		ins_a = 0;
		repeat (2) @(negedge sys_clk);
		check("supply before sync", 1'b1, sp_a);
		@(negedge sys_clk);
		check("supply after removal", 1'b0, sp_a);
		check("removed a", 1'b1, rm_a);
		check("removed b", 1'b0, rm_b);
		wait_rst(1'b0, 1'b0);
		ins_a = 1;
		repeat (20) @(negedge sys_clk);
		check("reinserted stays off", 1'b0, sp_a);
		$display("test removal done");
		// Restart with the stored selection on the second port
		rst = 1;
		repeat (6) @(negedge sys_clk);
		rst = 0;
		nv_sel = 1;
		nv_v = 1;
		@(negedge sys_clk);
		nv_v = 0;
		repeat (2) @(negedge sys_clk);
		check("stored port", 1'b1, act);
		check("removed cleared", 1'b0, rm_a);
		wait_rst(1'b1, 1'b1);
		check("port a idle", 1'b0, sp_a);
		$display("test restart done");
		final_report();
	end
endmodule
